// ### mph_pkg.sv
// shared constants and types for the modem parallel host port
package mph_pkg;
  localparam int FIFO_DEPTH = 16;
  localparam logic [4:0] CAP_FIFO = 5'h10;
  localparam logic [4:0] CAP_SINGLE = 5'h01;
  // register addresses on the three address lines
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_IER = 3'h1;
  localparam logic [2:0] ADDR_IIR = 3'h2;
  // fifo control shares the identification address, write side
  localparam logic [2:0] ADDR_FCR = 3'h2;
  localparam logic [2:0] ADDR_LCR = 3'h3;
  localparam logic [2:0] ADDR_MCR = 3'h4;
  localparam logic [2:0] ADDR_LSR = 3'h5;
  localparam logic [2:0] ADDR_MSR = 3'h6;
  localparam logic [2:0] ADDR_SCR = 3'h7;
  // fifo control field positions
  localparam int FCR_EN_BIT = 0;
  localparam int FCR_RXRST_BIT = 1;
  localparam int FCR_TXRST_BIT = 2;
  localparam int FCR_TRIG_LO = 6;
  localparam int FCR_TRIG_HI = 7;
  // interrupt enable bit positions
  localparam int IER_RX_BIT = 0;
  localparam int IER_TX_BIT = 1;
  localparam int IER_LINE_BIT = 2;
  localparam int IER_MODEM_BIT = 3;
  // interrupt identification codes
  localparam logic [3:0] IIR_NONE = 4'h1;
  localparam logic [3:0] IIR_LINE = 4'h6;
  localparam logic [3:0] IIR_RXDATA = 4'h4;
  localparam logic [3:0] IIR_TIMEOUT = 4'hc;
  localparam logic [3:0] IIR_TX_HOLDING_EMPTY_FLAG = 4'h2;
  localparam logic [3:0] IIR_MODEM = 4'h0;
  localparam logic [1:0] IIR_FIFO_FLAGS = 2'h3;
  // receive trigger levels indexed by the two-bit field
  localparam logic [3:0][4:0] TRIG_LEVELS = {5'h0e, 5'h08, 5'h04, 5'h01};
  // character timing in bit times
  localparam logic [3:0] START_BITS = 4'h1;
  localparam logic [3:0] MIN_DATA_BITS = 4'h5;
  localparam logic [3:0] STOP_BITS = 4'h1;
  localparam logic [5:0] TO_CHARS = 6'h04;
  // reset values
  localparam logic [3:0] IER_RESET = 4'h0;
  localparam logic [1:0] TRIG_RESET = 2'h0;
  localparam logic [4:0] MCR_RESET = 5'h00;
  localparam logic [15:0] DIVISOR_RESET = 16'h0000;
  localparam logic [7:0] SCR_RESET = 8'h00;

  typedef struct packed {
    logic select_n;
    logic read_n;
    logic write_n;
    logic [2:0] addr;
    logic [7:0] data;
  } mph_host_bus_t;

  typedef struct packed {
    logic divisor_latch_access_bit;
    logic set_break;
    logic stick_parity;
    logic even_parity;
    logic parity_en;
    logic two_stop;
    logic [1:0] word_len;
  } mph_line_ctl_t;

  localparam mph_line_ctl_t LCR_RESET = '0;

  typedef enum logic {TX_HOLDING_EMPTY_FLAG_IDLE, TX_HOLDING_EMPTY_FLAG_WAIT} mph_tx_holding_empty_flag_state_t;
endpackage

// ### mph_fifo.sv
// sixteen-entry byte fifo with registered head output
`timescale 1ns/1ps
module mph_fifo (
  input wire logic mclk,
  input wire logic reset,
  input wire logic flush,
  input wire logic [4:0] cap,
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [7:0] out_data,
  input wire logic out_ready,
  output logic [4:0] count
);
  import mph_pkg::*;
  logic [7:0] mem [FIFO_DEPTH];
  logic [3:0] wptr, rptr, next_wptr, next_rptr;
  logic [4:0] next_count;
  logic next_in_ready, next_out_valid, push, pop;
  logic [7:0] next_out_data;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    next_wptr = wptr + 4'(push);
    next_rptr = rptr + 4'(pop);
    next_count = count + 5'(push) - 5'(pop);
    // head bypass when the new head is the word written now
    next_out_data = (push && next_rptr == wptr) ? in_data : mem[next_rptr];
    if (flush) begin
      next_wptr = 4'h0;
      next_rptr = 4'h0;
      next_count = 5'h00;
    end
    next_in_ready = next_count < cap;
    next_out_valid = next_count != 5'h00;
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wptr] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      wptr <= 4'h0;
      rptr <= 4'h0;
      count <= 5'h00;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
      out_data <= 8'h00;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      count <= next_count;
      in_ready <= next_in_ready;
      out_valid <= next_out_valid;
      out_data <= next_out_data;
    end
  end
endmodule // mph_fifo

// ### mph_host_port.sv
// parallel host register port of the modem with receive and transmit fifos
// What this block does
// - write strobe low while selected stores the byte into the addressed register
// - read strobe low while selected returns the addressed register's contents
// - strobes are ignored unless device select is low
// - address lines pick the register; divisor latch bit reroutes addresses 0 and 1
// - separate sixteen-byte receive and transmit fifos
// - fifo enable bit set makes both fifos operative
// - fifo enable clear gives single-byte receive and transmit buffering
// - receive buffer reads pull one byte per read from the receive fifo
// - transmit buffer writes queue into the transmit fifo
// - data ready flag set while the receive fifo is not empty
// - code 4h while receive count is at or above the trigger level
// - interrupt output follows receive count against trigger level
// - code Ch in fifo mode when data waits, no arrival and no read for four characters
// - second stop bit counts inside the character time
// - code 2h when the transmit buffer is empty and enabled
// - transmit buffer write or identification read clears the empty interrupt
// - in fifo mode, empty indication delayed one character less a stop bit unless two bytes queued
// - first empty interrupt after fifo enable is immediate
// - interrupt output high while any enabled condition is pending, low after service
`timescale 1ns/1ps
module mph_host_port (
  input wire logic mclk,
  input wire logic reset,
  input wire mph_pkg::mph_host_bus_t host_bus,
  output logic [7:0] host_data_out,
  output logic host_data_oe,
  output logic host_interrupt_output,
  input wire logic bit_tick,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  input wire logic rx_line_error,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic [3:0] modem_lines,
  output mph_pkg::mph_line_ctl_t line_control,
  output logic [15:0] divisor,
  output logic [4:0] modem_control
);
  import mph_pkg::*;

  // host access decode
  logic rd_act, wr_act, rd_act_q, wr_act_q, rd_evt, wr_evt, divisor_latch_access_bit;
  logic [2:0] addr;
  logic wr_thr, wr_dll, wr_dlm, wr_ier, wr_fcr, wr_lcr, wr_mcr, wr_scr;
  logic rd_rbr, rd_iir, rd_lsr, rd_msr;

  assign rd_act = ~host_bus.select_n & ~host_bus.read_n;
  assign wr_act = ~host_bus.select_n & ~host_bus.write_n;
  assign rd_evt = rd_act & ~rd_act_q;
  assign wr_evt = wr_act & ~wr_act_q;
  assign addr = host_bus.addr;
  assign divisor_latch_access_bit = line_control.divisor_latch_access_bit;
  assign wr_thr = wr_evt & (addr == ADDR_DATA) & ~divisor_latch_access_bit;
  assign wr_dll = wr_evt & (addr == ADDR_DATA) & divisor_latch_access_bit;
  assign wr_ier = wr_evt & (addr == ADDR_IER) & ~divisor_latch_access_bit;
  assign wr_dlm = wr_evt & (addr == ADDR_IER) & divisor_latch_access_bit;
  assign wr_fcr = wr_evt & (addr == ADDR_IIR);
  assign wr_lcr = wr_evt & (addr == ADDR_LCR);
  assign wr_mcr = wr_evt & (addr == ADDR_MCR);
  assign wr_scr = wr_evt & (addr == ADDR_SCR);
  assign rd_rbr = rd_evt & (addr == ADDR_DATA) & ~divisor_latch_access_bit;
  assign rd_iir = rd_evt & (addr == ADDR_IIR);
  assign rd_lsr = rd_evt & (addr == ADDR_LSR);
  assign rd_msr = rd_evt & (addr == ADDR_MSR);

  // register state
  logic [3:0] ier, next_ier, msr_delta, next_msr_delta, modem_q;
  logic fifo_mode, next_fifo_mode, err_flag, next_err_flag;
  logic [1:0] trig, next_trig;
  logic [7:0] scratch, next_scratch, next_host_data_out, rd_mux;
  mph_line_ctl_t next_line_control;
  logic [15:0] next_divisor;
  logic [4:0] next_modem_control;
  logic rx_flush, tx_flush, fifo_on;
  logic [3:0] iir_code;

  // fifos and transmit buffer wires
  logic [4:0] rx_count, tx_count, cap;
  logic rx_head_valid, tx_head_valid, rx_push, rx_nonempty, tx_empty, buf_in_ready;
  logic [7:0] rx_head, tx_head;

  assign cap = fifo_mode ? CAP_FIFO : CAP_SINGLE;
  assign fifo_on = wr_fcr & host_bus.data[FCR_EN_BIT] & ~fifo_mode;
  assign rx_flush = wr_fcr & (host_bus.data[FCR_RXRST_BIT] | (host_bus.data[FCR_EN_BIT] != fifo_mode));
  assign tx_flush = wr_fcr & (host_bus.data[FCR_TXRST_BIT] | (host_bus.data[FCR_EN_BIT] != fifo_mode));
  assign rx_push = rx_valid & rx_ready;
  assign rx_nonempty = rx_count != 5'h00;
  assign tx_empty = tx_count == 5'h00;

  always_comb begin
    next_ier = ier;
    next_fifo_mode = fifo_mode;
    next_trig = trig;
    next_line_control = line_control;
    next_divisor = divisor;
    next_modem_control = modem_control;
    next_scratch = scratch;
    if (wr_ier) next_ier = host_bus.data[3:0];
    if (wr_dll) next_divisor[7:0] = host_bus.data;
    if (wr_dlm) next_divisor[15:8] = host_bus.data;
    if (wr_fcr) begin
      next_fifo_mode = host_bus.data[FCR_EN_BIT];
      next_trig = host_bus.data[FCR_TRIG_HI:FCR_TRIG_LO];
    end
    if (wr_lcr) next_line_control = mph_line_ctl_t'(host_bus.data);
    if (wr_mcr) next_modem_control = host_bus.data[4:0];
    if (wr_scr) next_scratch = host_bus.data;
    // hardware set wins over the clearing read
    next_err_flag = rx_line_error | (err_flag & ~rd_lsr);
    next_msr_delta = (modem_lines ^ modem_q) | (msr_delta & ~{4{rd_msr}});
    unique case (addr)
      ADDR_DATA: rd_mux = divisor_latch_access_bit ? divisor[7:0] : rx_head;
      ADDR_IER: rd_mux = divisor_latch_access_bit ? divisor[15:8] : {4'h0, ier};
      ADDR_IIR: rd_mux = {fifo_mode ? IIR_FIFO_FLAGS : 2'h0, 2'h0, iir_code};
      ADDR_LCR: rd_mux = line_control;
      ADDR_MCR: rd_mux = {3'h0, modem_control};
      ADDR_LSR: rd_mux = {fifo_mode & err_flag, tx_empty & ~tx_valid, tx_empty, 1'b0, err_flag, 2'h0, rx_nonempty};
      ADDR_MSR: rd_mux = {modem_q, msr_delta};
      ADDR_SCR: rd_mux = scratch;
    endcase
    next_host_data_out = rd_evt ? rd_mux : host_data_out;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ier <= IER_RESET;
      fifo_mode <= 1'b0;
      trig <= TRIG_RESET;
      line_control <= LCR_RESET;
      divisor <= DIVISOR_RESET;
      modem_control <= MCR_RESET;
      scratch <= SCR_RESET;
      err_flag <= 1'b0;
      msr_delta <= 4'h0;
      modem_q <= 4'h0;
      rd_act_q <= 1'b0;
      wr_act_q <= 1'b0;
      host_data_out <= 8'h00;
      host_data_oe <= 1'b0;
    end else begin
      ier <= next_ier;
      fifo_mode <= next_fifo_mode;
      trig <= next_trig;
      line_control <= next_line_control;
      divisor <= next_divisor;
      modem_control <= next_modem_control;
      scratch <= next_scratch;
      err_flag <= next_err_flag;
      msr_delta <= next_msr_delta;
      modem_q <= modem_lines;
      rd_act_q <= rd_act;
      wr_act_q <= wr_act;
      host_data_out <= next_host_data_out;
      host_data_oe <= rd_act;
    end
  end

  mph_fifo u_rx_fifo (
    .mclk(mclk),
    .reset(reset),
    .flush(rx_flush),
    .cap(cap),
    .in_valid(rx_valid),
    .in_data(rx_data),
    .in_ready(rx_ready),
    .out_valid(rx_head_valid),
    .out_data(rx_head),
    .out_ready(rd_rbr),
    .count(rx_count)
  );

  mph_fifo u_tx_fifo (
    .mclk(mclk),
    .reset(reset),
    .flush(tx_flush),
    .cap(cap),
    .in_valid(wr_thr),
    .in_data(host_bus.data),
    .in_ready(),
    .out_valid(tx_head_valid),
    .out_data(tx_head),
    .out_ready(buf_in_ready),
    .count(tx_count)
  );

  // two-entry output buffer toward the datapump
  logic [1:0] buf_cnt, next_buf_cnt, after_pop;
  logic [7:0] buf1, next_buf1, next_tx_data;
  logic buf_push, buf_pop;

  assign buf_in_ready = buf_cnt != 2'h2;
  assign buf_push = tx_head_valid & buf_in_ready;
  assign buf_pop = tx_valid & tx_ready;
  assign after_pop = buf_cnt - 2'(buf_pop);

  always_comb begin
    next_buf_cnt = after_pop + 2'(buf_push);
    next_tx_data = buf_pop ? buf1 : tx_data;
    next_buf1 = buf1;
    if (buf_push) begin
      if (after_pop == 2'h0) next_tx_data = tx_head;
      else next_buf1 = tx_head;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      buf_cnt <= 2'h0;
      buf1 <= 8'h00;
      tx_data <= 8'h00;
      tx_valid <= 1'b0;
    end else begin
      buf_cnt <= next_buf_cnt;
      buf1 <= next_buf1;
      tx_data <= next_tx_data;
      tx_valid <= next_buf_cnt != 2'h0;
    end
  end

  // character timing, receive timeout and transmit-empty delay
  logic [3:0] chr_bits, dly_cnt, next_dly_cnt;
  logic [5:0] to_limit, to_cnt, next_to_cnt;
  logic [4:0] level;
  logic to_hit, tx_empty_q, tx_holding_empty_flag_rise, seen_two, next_seen_two, tx_holding_empty_flag_irq, next_tx_holding_empty_flag_irq, tx_holding_empty_flag_set, tx_holding_empty_flag_clr;
  mph_tx_holding_empty_flag_state_t tx_holding_empty_flag_state, next_tx_holding_empty_flag_state;
  logic line_int, rx_int, to_int, tx_int, ms_int;

  assign chr_bits = START_BITS + MIN_DATA_BITS + STOP_BITS + {2'h0, line_control.word_len}
                    + {3'h0, line_control.parity_en} + {3'h0, line_control.two_stop};
  assign to_limit = {2'h0, chr_bits} * TO_CHARS;
  assign level = fifo_mode ? TRIG_LEVELS[trig] : CAP_SINGLE;
  assign to_hit = fifo_mode & rx_nonempty & (to_cnt >= to_limit);
  assign tx_holding_empty_flag_rise = tx_empty & ~tx_empty_q;

  always_comb begin
    // arrival, host read or empty fifo restart the measurement
    if (rx_push | rd_rbr | ~rx_nonempty) next_to_cnt = 6'h00;
    else if (bit_tick & (to_cnt < to_limit)) next_to_cnt = to_cnt + 6'h01;
    else next_to_cnt = to_cnt;
    next_seen_two = tx_holding_empty_flag_rise ? 1'b0 : (seen_two | (tx_count >= 5'h02));
    next_tx_holding_empty_flag_state = tx_holding_empty_flag_state;
    next_dly_cnt = dly_cnt;
    tx_holding_empty_flag_set = 1'b0;
    unique case (tx_holding_empty_flag_state)
      TX_HOLDING_EMPTY_FLAG_IDLE: begin
        if (tx_holding_empty_flag_rise) begin
          if (fifo_mode & ~seen_two) begin
            next_tx_holding_empty_flag_state = TX_HOLDING_EMPTY_FLAG_WAIT;
            next_dly_cnt = 4'h0;
          end else begin
            tx_holding_empty_flag_set = 1'b1;
          end
        end
      end
      TX_HOLDING_EMPTY_FLAG_WAIT: begin
        if (~tx_empty) begin
          next_tx_holding_empty_flag_state = TX_HOLDING_EMPTY_FLAG_IDLE;
        end else if (bit_tick) begin
          next_dly_cnt = dly_cnt + 4'h1;
          if (next_dly_cnt >= chr_bits - STOP_BITS) begin
            tx_holding_empty_flag_set = 1'b1;
            next_tx_holding_empty_flag_state = TX_HOLDING_EMPTY_FLAG_IDLE;
          end
        end
      end
    endcase
    if (fifo_on) begin
      tx_holding_empty_flag_set = 1'b1;
      next_tx_holding_empty_flag_state = TX_HOLDING_EMPTY_FLAG_IDLE;
    end
    if (wr_ier & host_bus.data[IER_TX_BIT] & ~ier[IER_TX_BIT] & tx_empty) tx_holding_empty_flag_set = 1'b1;
    tx_holding_empty_flag_clr = wr_thr | (rd_iir & (iir_code == IIR_TX_HOLDING_EMPTY_FLAG));
    next_tx_holding_empty_flag_irq = tx_holding_empty_flag_set | (tx_holding_empty_flag_irq & ~tx_holding_empty_flag_clr);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      to_cnt <= 6'h00;
      seen_two <= 1'b0;
      tx_empty_q <= 1'b1;
      tx_holding_empty_flag_state <= TX_HOLDING_EMPTY_FLAG_IDLE;
      dly_cnt <= 4'h0;
      tx_holding_empty_flag_irq <= 1'b0;
      host_interrupt_output <= 1'b0;
    end else begin
      to_cnt <= next_to_cnt;
      seen_two <= next_seen_two;
      tx_empty_q <= tx_empty;
      tx_holding_empty_flag_state <= next_tx_holding_empty_flag_state;
      dly_cnt <= next_dly_cnt;
      tx_holding_empty_flag_irq <= next_tx_holding_empty_flag_irq;
      host_interrupt_output <= iir_code != IIR_NONE;
    end
  end

  // prioritised identification code
  assign line_int = ier[IER_LINE_BIT] & err_flag;
  assign rx_int = ier[IER_RX_BIT] & (rx_count >= level);
  assign to_int = ier[IER_RX_BIT] & to_hit;
  assign tx_int = ier[IER_TX_BIT] & tx_holding_empty_flag_irq;
  assign ms_int = ier[IER_MODEM_BIT] & (msr_delta != 4'h0);

  always_comb begin
    if (line_int) iir_code = IIR_LINE;
    else if (rx_int) iir_code = IIR_RXDATA;
    else if (to_int) iir_code = IIR_TIMEOUT;
    else if (tx_int) iir_code = IIR_TX_HOLDING_EMPTY_FLAG;
    else if (ms_int) iir_code = IIR_MODEM;
    else iir_code = IIR_NONE;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  chk_select_gate: assert property (host_bus.select_n |=> !host_data_oe) else $error("data driven while deselected");
  chk_write_store: assert property (wr_scr |=> scratch == $past(host_bus.data)) else $error("scratch not stored");
  chk_read_return: assert property (rd_evt && addr == ADDR_SCR |=> host_data_out == $past(scratch)) else $error("bad read data");
  chk_divisor_latch_access_bit_route: assert property (wr_evt && divisor_latch_access_bit && addr == ADDR_DATA |=> divisor[7:0] == $past(host_bus.data) && tx_count == $past(tx_count)) else $error("divisor write misrouted");
  chk_fifo_depth: assert property (rx_count <= CAP_FIFO && tx_count <= CAP_FIFO) else $error("fifo over depth");
  chk_fifo_enable: assert property (fifo_on |=> fifo_mode ##0 tx_holding_empty_flag_irq) else $error("fifo enable not immediate");
  chk_single_depth: assert property (!fifo_mode && !$past(fifo_mode) |-> rx_count <= CAP_SINGLE) else $error("non-fifo holds more than one byte");
  chk_rx_trigger: assert property (fifo_mode && ier[IER_RX_BIT] && rx_count >= level |=> host_interrupt_output) else $error("trigger level not signalled");
  chk_timeout_code: assert property (to_hit && ier[IER_RX_BIT] && !rx_int && !line_int |-> iir_code == IIR_TIMEOUT) else $error("timeout code missing");
  chk_read_restart: assert property (rd_rbr && fifo_mode |=> to_cnt == 6'h00) else $error("timeout not restarted");
  chk_tx_holding_empty_flag_delay: assert property (tx_holding_empty_flag_rise && fifo_mode && !seen_two && !fifo_on && !tx_holding_empty_flag_irq && !wr_ier |=> !tx_holding_empty_flag_irq) else $error("empty indication not delayed");
  chk_tx_holding_empty_flag_clear: assert property (wr_thr && !tx_holding_empty_flag_set |=> !tx_holding_empty_flag_irq) else $error("transmit write left empty interrupt");
  chk_ready_flag: assert property (rx_push && !rx_flush |=> rx_nonempty) else $error("data ready flag not set");

  cov_timeout: cover property (to_int && iir_code == IIR_TIMEOUT);
  cov_delayed_tx_holding_empty_flag: cover property (tx_holding_empty_flag_state == TX_HOLDING_EMPTY_FLAG_WAIT ##[1:200] tx_holding_empty_flag_irq);
  cov_rx_full: cover property (rx_count == CAP_FIFO);
  cov_tx_stall: cover property (tx_valid && !tx_ready && buf_cnt == 2'h2);
endmodule // mph_host_port

// ### mph_pump_model.sv
// datapump stand-in: bit ticks, receive byte source, transmit byte sink
`timescale 1ns/1ps
module mph_pump_model (
  input wire logic mclk,
  input wire logic reset,
  input wire logic tx_stall,
  output logic bit_tick,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  logic [1:0] div;
  logic [7:0] got [$];
  initial begin
    div = 2'h0;
    bit_tick = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
  end
  // one bit time every four clocks
  always @(posedge mclk) begin
    div <= div + 2'h1;
    bit_tick <= (div == 2'h3);
    tx_ready <= !tx_stall && !reset;
    if (tx_valid && tx_ready)
      got.push_back(tx_data);
  end
  // byte held until taken; abandoned after a bounded wait
  task automatic send(input logic [7:0] b);
    int i;
    @(posedge mclk);
    rx_valid <= 1'b1;
    rx_data <= b;
    for (i = 0; i < 40; i++) begin
      @(negedge mclk);
      if (rx_ready)
        break;
      @(posedge mclk);
    end
    @(posedge mclk);
    rx_valid <= 1'b0;
    rx_data <= ~b;
  endtask
endmodule // mph_pump_model

// ### mph_host_port_test.sv
// self-checking bench for the modem parallel host port
`timescale 1ns/1ps
module mph_host_port_test;
  import mph_pkg::*;
  logic mclk, reset, tx_stall, bit_tick, rx_valid, rx_ready, tx_valid, tx_ready, irq;
  logic [7:0] rx_data, tx_data, host_data_out, q;
  logic [15:0] divisor;
  mph_host_bus_t bus;
  int n_fail = 0;
  int samples_checked = 0;
  int lv [4] = '{1, 4, 8, 14};
  mph_host_port u_mph_host_port (.mclk(mclk), .reset(reset), .host_bus(bus), .host_data_out(host_data_out),
    .host_data_oe(), .host_interrupt_output(irq), .bit_tick(bit_tick), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .rx_line_error(1'b0), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .modem_lines(4'h0), .line_control(), .divisor(divisor), .modem_control());
  mph_pump_model u_mph_pump_model (.mclk(mclk), .reset(reset), .tx_stall(tx_stall), .bit_tick(bit_tick),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic report_and_stop();
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one host access; strobe held three edges, read data taken mid-cycle
  task automatic acc(input logic sel_n, input logic w, input logic [2:0] a, input logic [7:0] d,
    output logic [7:0] r);
    @(posedge mclk);
    bus <= '{sel_n, w, !w, a, d};
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    r = host_data_out;
    @(posedge mclk);
    bus <= '{1'b1, 1'b1, 1'b1, a, ~d};
    @(posedge mclk);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] r;
    acc(1'b0, 1'b1, a, d, r);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] r);
    acc(1'b0, 1'b0, a, 8'h00, r);
  endtask
  task automatic wait_tx(input int n);
    int k;
    for (k = 0; k < 400 && u_mph_pump_model.got.size() < n; k++)
      @(posedge mclk);
    if (u_mph_pump_model.got.size() < n) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  initial begin
    repeat (60000) @(posedge mclk);
    n_fail++;
    report_and_stop();
  end
  initial begin
    bus = '{1'b1, 1'b1, 1'b1, 3'h0, 8'h00};
    reset = 1'b1;
    tx_stall = 1'b0;
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(negedge mclk);
    chk("irq after reset", irq, 1'b0);
    rd(ADDR_IIR, q);
    chk("iir single mode", q, 8'h01);
    wr(ADDR_SCR, 8'h5a);
    rd(ADDR_SCR, q);
    chk("scratch", q, 8'h5a);
    acc(1'b1, 1'b1, ADDR_SCR, 8'ha5, q);
    rd(ADDR_SCR, q);
    chk("scratch unselected", q, 8'h5a);
    wr(ADDR_LCR, 8'h80);
    wr(ADDR_DATA, 8'h34);
    wr(ADDR_IER, 8'h12);
    chk("divisor", divisor, 16'h1234);
    wr(ADDR_LCR, 8'h00);
    rd(ADDR_IER, q);
    chk("ier untouched", q, 8'h00);
    u_mph_pump_model.send(8'h11);
    repeat (2) @(negedge mclk);
    chk("ready single", rx_ready, 1'b0);
    rd(ADDR_DATA, q);
    chk("rx single", q, 8'h11);
    // fifo mode: fill until refused, then drain in order
    wr(ADDR_IER, 8'h01);
    wr(ADDR_FCR, 8'h01);
    for (int i = 0; i < 16; i++) begin
      if (i == 15)
        chk("ready at 15", rx_ready, 1'b1);
      u_mph_pump_model.send(8'h20 + i[7:0]);
    end
    repeat (2) @(negedge mclk);
    chk("ready full", rx_ready, 1'b0);
    rd(ADDR_LSR, q);
    chk("data ready", q[0], 1'b1);
    for (int i = 0; i < 16; i++) begin
      rd(ADDR_DATA, q);
      chk("rx fifo byte", q, 8'h20 + i[7:0]);
    end
    rd(ADDR_LSR, q);
    chk("data ready empty", q[0], 1'b0);
    // every trigger field value
    for (int t = 0; t < 4; t++) begin
      wr(ADDR_FCR, {t[1:0], 6'h03});
      for (int i = 1; i < lv[t]; i++)
        u_mph_pump_model.send(i[7:0]);
      rd(ADDR_IIR, q);
      chk("iir below level", q, 8'hc1);
      u_mph_pump_model.send(8'h55);
      rd(ADDR_IIR, q);
      chk("iir at level", q, 8'hc4);
      chk("irq at level", irq, 1'b1);
      rd(ADDR_DATA, q);
      rd(ADDR_IIR, q);
      chk("iir dropped", q, 8'hc1);
      chk("irq dropped", irq, 1'b0);
    end
    // one and two stop bits: 28 versus 32 bit times
    for (int s = 0; s < 2; s++) begin
      wr(ADDR_LCR, s ? 8'h04 : 8'h00);
      wr(ADDR_FCR, 8'h43);
      u_mph_pump_model.send(8'h77);
      repeat (120) @(posedge mclk);
      rd(ADDR_IIR, q);
      chk("timeout at 30", q, s ? 8'hc1 : 8'hcc);
      repeat (20) @(posedge mclk);
      rd(ADDR_IIR, q);
      chk("timeout late", q, 8'hcc);
      rd(ADDR_DATA, q);
      rd(ADDR_IIR, q);
      chk("timeout cleared", q, 8'hc1);
    end
    // transmit empty interrupt
    wr(ADDR_FCR, 8'h00);
    wr(ADDR_IER, 8'h02);
    rd(ADDR_IIR, q);
    wr(ADDR_FCR, 8'h01);
    chk("irq tx empty", irq, 1'b1);
    rd(ADDR_IIR, q);
    chk("first empty", q, 8'hc2);
    rd(ADDR_IIR, q);
    chk("cleared by read", q, 8'hc1);
    @(posedge mclk);
    tx_stall <= 1'b1;
    for (int i = 0; i < 5; i++)
      wr(ADDR_DATA, 8'ha0 + i[7:0]);
    rd(ADDR_IIR, q);
    chk("cleared by write", q, 8'hc1);
    @(posedge mclk);
    tx_stall <= 1'b0;
    wait_tx(5);
    for (int i = 0; i < 5; i++)
      chk("tx byte", u_mph_pump_model.got[i], 8'ha0 + i[7:0]);
    repeat (4) @(posedge mclk);
    rd(ADDR_IIR, q);
    chk("empty after burst", q, 8'hc2);
    wr(ADDR_DATA, 8'hb5);
    wait_tx(6);
    rd(ADDR_IIR, q);
    chk("empty delayed", q, 8'hc1);
    repeat (40) @(posedge mclk);
    rd(ADDR_IIR, q);
    chk("empty after delay", q, 8'hc2);
    report_and_stop();
  end
endmodule // mph_host_port_test
